// [design/fpdc_ctrl.v]
// host controller driving a 512k x 40 fast page dram module
`timescale 1ns/1ps
`include "fpdc_map.vh"
module fpdc_ctrl #(
   parameter PWRUP_CYC = `FPDC_N_PWRUP,
   parameter REF_CYC   = `FPDC_N_REF_INT,
   parameter BBU_CYC   = `FPDC_N_BBU,
   parameter DW        = 40
) (
   // clock and reset
   input  wire          clk,
   input  wire          resetn,
   // user request side
   input  wire          req_valid,
   input  wire          req_write,
   input  wire [17:0]   req_addr,
   input  wire [DW-1:0] req_wdata,
   input  wire          req_bank,
   input  wire [1:0]    req_lanes,
   input  wire          battery_mode,
   output reg           req_ready,
   output reg           rsp_valid,
   output reg  [DW-1:0] rsp_rdata,
   output reg           init_done,
   // dram pins
   output reg           row_strobe_bank0_n,
   output reg           row_strobe_bank1_n,
   output reg           column_strobe_lane0_n,
   output reg           column_strobe_lane1_n,
   output reg           write_enable_n,
   output reg           output_enable_n,
   output reg  [8:0]    multiplexed_address,
   output reg  [DW-1:0] data_lines_out,
   output reg           data_lines_oe,
   input  wire [DW-1:0] data_lines_in
);
   // states
   localparam S_PWRUP = 4'h0, S_IDLE = 4'h1, S_RCD = 4'h2, S_CAS = 4'h3;
   localparam S_CP = 4'h4, S_CSR = 4'h6, S_CBR = 4'h7, S_RP = 4'h8;
   localparam TW = 21;
   localparam [TW-1:0] T_RCD = `FPDC_N_RCD, T_CAS = `FPDC_N_CAS, T_CP = `FPDC_N_CP;
   localparam [TW-1:0] T_RP = `FPDC_N_RP, T_CSR = `FPDC_N_CSR, T_RAS = `FPDC_N_RAS;
   localparam [3:0]    T_WAKE = `FPDC_WAKE_CYCLES;   // waits above cut to timer width
   // reset release through two flops
   reg rst_m_r, rst_n_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_m_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n_r <= rst_m_r;
      end
   end

   // read data pins synchronised before use
   reg [DW-1:0] din_m_r, din_s_r;
   always @(posedge clk) begin
      din_m_r <= data_lines_in;
      din_s_r <= din_m_r;
   end
   reg [3:0]    st_r;          // controller state
   reg [8:0]    open_row_r;    // row held open in page mode
   reg          open_bank_r;   // bank whose row strobe is low
   reg          wr_r;          // current column access is a write
   reg [1:0]    lanes_r;       // lanes strobed this access
   reg [DW-1:0] wdata_r;       // write data held on pins
   reg [TW-1:0] ras_cnt_r;     // cycles row strobe has been low
   reg [TW-1:0] ref_cnt_r;     // refresh interval timer
   reg          ref_pend_r;    // a refresh row cycle is owed
   reg [3:0]    wake_r;        // wake-up row cycles left
   reg          t_load;        // start the shared wait timer
   reg [TW-1:0] t_val;         // wait length
   wire         t_done;        // wait elapsed

   fpdc_timer #(.W(TW)) u_tmr (
      .clk   (clk),
      .rst_n (rst_n_r),
      .load  (t_load),
      .value (t_val),
      .done  (t_done)
   );
   wire [TW-1:0] ref_period = battery_mode ? BBU_CYC[TW-1:0] : REF_CYC[TW-1:0];
   wire ras_low   = ~row_strobe_bank0_n | ~row_strobe_bank1_n;
   wire ras_minok = ras_cnt_r >= `FPDC_N_RAS;
   // leave page before the long limit, leaving room for one more column cycle
   wire ras_late  = ras_cnt_r >= (`FPDC_N_RASP - 8);
   wire same_page = req_valid & (req_addr[17:9] == open_row_r)
                    & (req_bank == open_bank_r);

   // refresh interval timer; a late refresh is owed, not dropped
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ref_cnt_r  <= {TW{1'b0}};
         ref_pend_r <= 1'b0;
      end else begin
         if (ref_cnt_r >= ref_period) begin
            ref_cnt_r  <= {TW{1'b0}};
            ref_pend_r <= 1'b1;
         end else begin
            ref_cnt_r <= ref_cnt_r + {{(TW-1){1'b0}}, 1'b1};
            if (st_r == S_CBR && t_done && ras_minok)
               ref_pend_r <= 1'b0;
         end
      end
   end
   // row strobe low-time counter
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r)
         ras_cnt_r <= {TW{1'b0}};
      else if (ras_low)
         ras_cnt_r <= ras_cnt_r + {{(TW-1){1'b0}}, 1'b1};
      else
         ras_cnt_r <= {TW{1'b0}};
   end
   // main sequencer; every pin comes straight from a flop
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r                  <= S_PWRUP;
         row_strobe_bank0_n    <= 1'b1;
         row_strobe_bank1_n    <= 1'b1;
         column_strobe_lane0_n <= 1'b1;
         column_strobe_lane1_n <= 1'b1;
         write_enable_n        <= 1'b1;
         output_enable_n       <= 1'b1;
         multiplexed_address   <= 9'h000;
         data_lines_out        <= {DW{1'b0}};
         data_lines_oe         <= 1'b0;
         req_ready             <= 1'b0;
         rsp_valid             <= 1'b0;
         rsp_rdata             <= {DW{1'b0}};
         init_done             <= 1'b0;
         open_row_r            <= 9'h000;
         open_bank_r           <= 1'b0;
         wr_r                  <= 1'b0;
         lanes_r               <= 2'h0;
         wdata_r               <= {DW{1'b0}};
         wake_r                <= 4'h0;
         t_load                <= 1'b1;
         t_val                 <= PWRUP_CYC[TW-1:0];
      end else begin
         t_load    <= 1'b0;
         rsp_valid <= 1'b0;
         req_ready <= 1'b0;
         case (st_r)
            S_PWRUP: begin
               // wait, then eight column-before-row wake cycles
               if (t_done && !t_load) begin
                  wake_r <= T_WAKE;
                  st_r   <= S_CSR;
                  column_strobe_lane0_n <= 1'b0;
                  column_strobe_lane1_n <= 1'b0;
                  t_load <= 1'b1;
                  t_val  <= T_CSR;
               end
            end
            S_IDLE: begin
               // standby: both strobes high; refresh never hides behind a read
               if (ref_pend_r && !ras_low) begin
                  st_r <= S_CSR;
                  column_strobe_lane0_n <= 1'b0;
                  column_strobe_lane1_n <= 1'b0;
                  t_load <= 1'b1;
                  t_val  <= T_CSR;
               end else if (req_valid && !ref_pend_r && !battery_mode && t_done) begin
                  // open row: address and row strobe change on the same edge
                  multiplexed_address <= req_addr[17:9];
                  open_row_r          <= req_addr[17:9];
                  open_bank_r         <= req_bank;
                  row_strobe_bank0_n  <= req_bank;
                  row_strobe_bank1_n  <= ~req_bank;
                  st_r   <= S_RCD;
                  t_load <= 1'b1;
                  t_val  <= T_RCD;
               end
            end
            S_RCD: begin
               // row to column delay, then start a column access
               write_enable_n <= ~(req_valid & req_write);
               if (t_done && !t_load && req_valid) begin
                  multiplexed_address <= req_addr[8:0];
                  wr_r    <= req_write;
                  lanes_r <= req_lanes;
                  wdata_r <= req_wdata;
                  data_lines_out <= req_wdata;
                  data_lines_oe  <= req_write;
                  // enable already fell two cycles ahead, so outputs stay open
                  write_enable_n  <= ~req_write;
                  output_enable_n <= req_write;
                  column_strobe_lane0_n <= ~req_lanes[0];
                  column_strobe_lane1_n <= ~req_lanes[1];
                  req_ready <= 1'b1;
                  st_r   <= S_CAS;
                  t_load <= 1'b1;
                  t_val  <= T_CAS;
               end
            end
            S_CAS: begin
               // column strobe low; hold write enable long enough before rise
               if (t_done && !t_load && ras_minok) begin
                  if (!wr_r)
                     rsp_rdata <= din_s_r;
                  rsp_valid <= ~wr_r;
                  column_strobe_lane0_n <= 1'b1;
                  column_strobe_lane1_n <= 1'b1;
                  st_r   <= S_CP;
                  t_load <= 1'b1;
                  t_val  <= T_CP;
               end
            end
            S_CP: begin
               // column precharge; stay in page or close the row
               write_enable_n  <= 1'b1;
               output_enable_n <= 1'b1;
               data_lines_oe   <= 1'b0;
               if (t_done && !t_load) begin
                  if (same_page && !ref_pend_r && !ras_late) begin
                     st_r <= S_RCD;
                     t_load <= 1'b1;
                     t_val  <= {{(TW-1){1'b0}}, 1'b1};
                  end else begin
                     row_strobe_bank0_n <= 1'b1;
                     row_strobe_bank1_n <= 1'b1;
                     st_r   <= S_RP;
                     t_load <= 1'b1;
                     t_val  <= T_RP;
                  end
               end
            end
            S_CSR: begin
               // column strobes low ahead of row strobe fall
               if (t_done && !t_load) begin
                  row_strobe_bank0_n <= 1'b0;
                  row_strobe_bank1_n <= 1'b0;
                  st_r   <= S_CBR;
                  t_load <= 1'b1;
                  t_val  <= T_RAS;
               end
            end
            S_CBR: begin
               // row strobe low at least min, well under 1us
               if (t_done && !t_load && ras_minok) begin
                  row_strobe_bank0_n    <= 1'b1;
                  row_strobe_bank1_n    <= 1'b1;
                  column_strobe_lane0_n <= 1'b1;
                  column_strobe_lane1_n <= 1'b1;
                  if (wake_r != 4'h0)
                     wake_r <= wake_r - 4'h1;
                  st_r   <= S_RP;
                  t_load <= 1'b1;
                  t_val  <= T_RP;
               end
            end
            S_RP: begin
               // row precharge, cycle time kept by rp plus ras min
               if (t_done && !t_load) begin
                  if (wake_r != 4'h0) begin
                     st_r <= S_CSR;
                     column_strobe_lane0_n <= 1'b0;
                     column_strobe_lane1_n <= 1'b0;
                     t_load <= 1'b1;
                     t_val  <= T_CSR;
                  end else begin
                     init_done <= 1'b1;
                     st_r <= S_IDLE;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule

// [design/fpdc_map.vh]
// timing and geometry constants for the fast page dram controller
`ifndef FPDC_MAP_VH
`define FPDC_MAP_VH
// clock rate
`define FPDC_CLK_MHZ        20
`define FPDC_CLK_NS         50
// times in ns as printed (slowest grade unless noted)
`define FPDC_T_RC_NS        150
`define FPDC_T_PC_NS        45
`define FPDC_T_RAS_MIN_NS   80
`define FPDC_T_RASP_MAX_NS  100000
`define FPDC_T_RP_NS        60
`define FPDC_T_CP_NS        10
`define FPDC_T_RCD_NS       20
`define FPDC_T_CSR_NS       10
`define FPDC_T_CHR_NS       15
`define FPDC_T_WP_NS        15
`define FPDC_T_RWL_NS       20
`define FPDC_T_RAC_NS       80
`define FPDC_T_CAS_NS       20
// times in us / ms
`define FPDC_T_PWRUP_US     100
`define FPDC_T_REF_MS       8
`define FPDC_T_BBU_US       125
`define FPDC_T_BBU_RAS_US   1
// derived cycle counts: minimums round up, maximums round down
`define FPDC_CYC_MIN(ns)    (((ns) + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_CYC_MAX(ns)    ((ns) / `FPDC_CLK_NS)
`define FPDC_N_RC           `FPDC_CYC_MIN(`FPDC_T_RC_NS)
`define FPDC_N_RAS          `FPDC_CYC_MIN(`FPDC_T_RAS_MIN_NS)
`define FPDC_N_RP           `FPDC_CYC_MIN(`FPDC_T_RP_NS)
`define FPDC_N_CP           `FPDC_CYC_MIN(`FPDC_T_CP_NS)
`define FPDC_N_RCD          `FPDC_CYC_MIN(`FPDC_T_RCD_NS)
`define FPDC_N_CSR          `FPDC_CYC_MIN(`FPDC_T_CSR_NS)
`define FPDC_N_CHR          `FPDC_CYC_MIN(`FPDC_T_CHR_NS)
`define FPDC_N_CAS          `FPDC_CYC_MIN(`FPDC_T_CAS_NS)
`define FPDC_N_RAC          `FPDC_CYC_MIN(`FPDC_T_RAC_NS)
`define FPDC_N_RASP         `FPDC_CYC_MAX(`FPDC_T_RASP_MAX_NS)
`define FPDC_N_PWRUP        (`FPDC_T_PWRUP_US * `FPDC_CLK_MHZ)
`define FPDC_N_REF_INT      (`FPDC_T_REF_MS * 1000 * `FPDC_CLK_MHZ / 512)
`define FPDC_N_BBU          (`FPDC_T_BBU_US * `FPDC_CLK_MHZ)
`define FPDC_N_BBU_RAS      (`FPDC_T_BBU_RAS_US * `FPDC_CLK_MHZ)
`define FPDC_WAKE_CYCLES    8
`define FPDC_ROWS           512
`endif

// [design/fpdc_timer.v]
// down-counter that marks when a programmed wait has elapsed
`timescale 1ns/1ps
module fpdc_timer #(
   parameter W = 12
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // control
   input  wire         load,
   input  wire [W-1:0] value,
   // status
   output wire         done
);
   reg [W-1:0] cnt_r;   // cycles still to wait

   // load wins over counting so a new wait starts cleanly
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {W{1'b0}};
      end else if (load) begin
         cnt_r <= value;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (cnt_r == {W{1'b0}}) & ~load;
endmodule

// [testbench/fpdc_ctrl_checker.sv]
// pin-level timing checks on the fast page dram controller
`timescale 1ns/1ps
module fpdc_ctrl_checker #(
   parameter PWRUP_CYC = 20,
   parameter REF_CYC   = 100,
   parameter BBU_CYC   = 200,
   parameter DW        = 40
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // user side
   input wire init_done,
   // dram pins
   input wire row_strobe_bank0_n,
   input wire row_strobe_bank1_n,
   input wire column_strobe_lane0_n,
   input wire column_strobe_lane1_n,
   input wire write_enable_n,
   input wire data_lines_oe
);
   localparam int GAP_MAX = REF_CYC + BBU_CYC; // widest legal refresh spacing
   reg  [15:0] gap_r;  // cycles since bank0 row strobe last fell
   reg  [3:0]  wake_r; // activations seen before init_done
   reg         r0_q_r; // bank0 row strobe one cycle back
   wire        r0_fall = r0_q_r & ~row_strobe_bank0_n;
   wire        row_lo = ~(row_strobe_bank0_n & row_strobe_bank1_n);
   // counters; wake count saturates so a long init cannot wrap it
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gap_r  <= 16'h0000;
         wake_r <= 4'h0;
         r0_q_r <= 1'b1;
      end else begin
         r0_q_r <= row_strobe_bank0_n;
         gap_r  <= r0_fall ? 16'h0000 : gap_r + 16'h0001;
         if (r0_fall && !init_done && wake_r != 4'hF) begin
            wake_r <= wake_r + 4'h1;
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_row_before_col: assert property ($fell(column_strobe_lane0_n) && row_lo |-> $past(row_lo))
      else $error("column strobe fell without a row open the cycle before");
   a_cbr_order: assert property ($fell(row_strobe_bank0_n) && !column_strobe_lane0_n
      |-> $past(column_strobe_lane0_n) == 1'b0 ##1 !column_strobe_lane0_n)
      else $error("refresh column strobe setup or hold too short");
   a_row_min_low: assert property ($fell(row_strobe_bank0_n) |-> (!row_strobe_bank0_n) [*2])
      else $error("row strobe low shorter than two cycles");
   a_row_precharge: assert property ($rose(row_strobe_bank1_n) |-> row_strobe_bank1_n [*2])
      else $error("row strobe high shorter than two cycles");
   a_early_write: assert property ($fell(write_enable_n)
      |-> column_strobe_lane0_n && column_strobe_lane1_n)
      else $error("write enable fell while a column strobe was low");
   a_we_lead: assert property ($rose(column_strobe_lane0_n) && $past(!write_enable_n)
      |-> $past(write_enable_n, 2) == 1'b0)
      else $error("write enable did not lead column strobe rise");
   a_drive_write: assert property (data_lines_oe |-> !write_enable_n && row_lo)
      else $error("data lines driven outside a write");
   a_refresh_gap: assert property (gap_r < GAP_MAX)
      else $error("row activations too far apart");
   a_wake_eight: assert property ($rose(init_done) |-> wake_r >= 4'h8)
      else $error("init done before eight wake cycles");
endmodule
bind fpdc_ctrl fpdc_ctrl_checker #(.PWRUP_CYC(PWRUP_CYC), .REF_CYC(REF_CYC), .BBU_CYC(BBU_CYC),
   .DW(DW)) fpdc_ctrl_checker_i (.clk(clk), .resetn(resetn), .init_done(init_done),
   .row_strobe_bank0_n(row_strobe_bank0_n), .row_strobe_bank1_n(row_strobe_bank1_n),
   .column_strobe_lane0_n(column_strobe_lane0_n), .column_strobe_lane1_n(column_strobe_lane1_n),
   .write_enable_n(write_enable_n), .data_lines_oe(data_lines_oe));

// [testbench/fpdc_dram_model.sv]
// behavioural model of the 512k x 40 fast page dram module
`timescale 1ns/1ps
module fpdc_dram_model #(
   parameter DW = 40
) (
   // strobes and controls
   input  wire          row_strobe_bank0_n,
   input  wire          row_strobe_bank1_n,
   input  wire          column_strobe_lane0_n,
   input  wire          column_strobe_lane1_n,
   input  wire          write_enable_n,
   input  wire          output_enable_n,
   input  wire [8:0]    multiplexed_address,
   // data lines
   input  wire [DW-1:0] data_from_ctrl,
   output reg  [DW-1:0] data_to_ctrl
);
   logic [DW-1:0] mem [int];   // sparse cells keyed by bank, row, column
   reg   [8:0]    row_r [2];   // latched row per bank
   wire           col_n = column_strobe_lane0_n & column_strobe_lane1_n;
   int            key;
   initial data_to_ctrl = '0;
   // a column-first fall is a refresh: no row is latched, pins ignored
   always @(negedge row_strobe_bank0_n) if (col_n) row_r[0] = multiplexed_address;
   always @(negedge row_strobe_bank1_n) if (col_n) row_r[1] = multiplexed_address;
   // each column fall under an open row is a fresh access; a closed row ends the page
   always @(negedge col_n) begin
      if (!(row_strobe_bank0_n & row_strobe_bank1_n)) begin
         #1;
         key = {row_strobe_bank0_n, row_r[row_strobe_bank0_n], multiplexed_address};
         if (!write_enable_n) begin
            mem[key] = data_from_ctrl;
         end else begin
            #19;
            if (!col_n && !output_enable_n) begin
               data_to_ctrl = mem.exists(key) ? mem[key] : ~data_to_ctrl;
            end
         end
      end
   end
   // released lines must not keep the old word, so show its inverse
   always @(posedge col_n) data_to_ctrl = ~data_to_ctrl;
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the fast page dram controller
`timescale 1ns/1ps
module tb_top;
   reg          clk, resetn, req_valid, req_write, req_bank, battery_mode;
   reg  [17:0]  req_addr;
   reg  [39:0]  req_wdata, rd;
   reg  [1:0]   req_lanes;
   wire         req_ready, rsp_valid, init_done, r0_n, r1_n, c0_n, c1_n, we_n, oe_n, d_oe;
   wire [39:0]  rsp_rdata, d_out, m_dq;
   wire [8:0]   addr;
   integer      fails, checks_done, falls;
   // the controller wins the data lines while it drives them
   wire [39:0]  d_in = d_oe ? d_out : m_dq;
   always #25 clk = ~clk;
   always @(negedge r0_n) falls = falls + 1;
   fpdc_ctrl #(.PWRUP_CYC(20), .REF_CYC(100), .BBU_CYC(200)) fpdc_ctrl_i (.clk(clk),
      .resetn(resetn), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_bank(req_bank), .req_lanes(req_lanes),
      .battery_mode(battery_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .init_done(init_done), .row_strobe_bank0_n(r0_n),
      .row_strobe_bank1_n(r1_n), .column_strobe_lane0_n(c0_n), .column_strobe_lane1_n(c1_n),
      .write_enable_n(we_n), .output_enable_n(oe_n), .multiplexed_address(addr),
      .data_lines_out(d_out), .data_lines_oe(d_oe), .data_lines_in(d_in));
   fpdc_dram_model fpdc_dram_model_i (.row_strobe_bank0_n(r0_n), .row_strobe_bank1_n(r1_n),
      .column_strobe_lane0_n(c0_n), .column_strobe_lane1_n(c1_n), .write_enable_n(we_n),
      .output_enable_n(oe_n), .multiplexed_address(addr), .data_from_ctrl(d_out),
      .data_to_ctrl(m_dq));
   // word stored at each place, unique per bank and address
   function [39:0] pat(input bk, input [17:0] a);
      pat = {bk, 3'h5, a, ~a};
   endfunction
   task summarize;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task check(input bit ok, input string msg);
      checks_done = checks_done + 1;
      if (!ok) begin
         fails = fails + 1;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // bounded wait on a level seen between edges; running out ends the run
   task wait_hi(input string what, input integer lim);
      integer n;
      n = 0;
      while (!(what == "ready" ? req_ready === 1'b1 : what == "rsp" ? rsp_valid === 1'b1
             : init_done === 1'b1) && n < lim) begin
         @(negedge clk);
         n = n + 1;
      end
      if (n >= lim) begin
         check(0, "wait timed out");
         summarize;
      end
   endtask
   task start(input bit wr, input bit bk, input [17:0] a);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_bank  <= bk;
      req_addr  <= a;
      req_wdata <= pat(bk, a);
      @(negedge clk);
   endtask
   // hold the request until taken, then collect read data
   task finish(input bit wr);
      wait_hi("ready", 400);
      @(posedge clk);
      req_valid <= 1'b0;
      if (!wr) begin
         wait_hi("rsp", 20);
         rd = rsp_rdata;
      end
   endtask
   task rd_check(input bit bk, input [17:0] a);
      start(0, bk, a);
      finish(0);
      check(rd === pat(bk, a), "read data mismatch");
   endtask
   task wr_word(input bit bk, input [17:0] a);
      start(1, bk, a);
      finish(1);
   endtask
   // back-to-back columns in one row, then read back in the open page
   task run_page;
      wr_word(0, {9'h005, 9'h003});
      wr_word(0, {9'h005, 9'h004});
      rd_check(0, {9'h005, 9'h003});
      rd_check(0, {9'h005, 9'h004});
   endtask
   // same column in another row and another bank must not alias
   task run_rows;
      wr_word(0, {9'h006, 9'h003});
      wr_word(1, {9'h005, 9'h003});
      rd_check(0, {9'h005, 9'h003});
      rd_check(0, {9'h006, 9'h003});
      rd_check(1, {9'h005, 9'h003});
   endtask
   // battery mode: refresh only, a waiting request is never taken
   task run_battery;
      integer i, f0, seen;
      @(posedge clk);
      battery_mode <= 1'b1;
      start(0, 0, {9'h006, 9'h003});
      f0 = falls;
      seen = 0;
      for (i = 0; i < 600; i = i + 1) begin
         @(negedge clk);
         if (req_ready === 1'b1) seen = 1;
      end
      check(seen == 0, "request taken in battery mode");
      check(falls - f0 >= 2 && falls - f0 <= 4, "battery refresh count off");
      @(posedge clk);
      battery_mode <= 1'b0;
      finish(0);
      check(rd === pat(0, {9'h006, 9'h003}), "read after battery mode");
   endtask
   // idle traffic still gets periodic refresh
   task run_idle;
      integer f0;
      f0 = falls;
      repeat (500) @(posedge clk);
      check(falls - f0 >= 4, "too few idle refreshes");
   endtask
   // reset mid-run: pins park, then a fresh wake-up before service
   task run_reset;
      integer f0;
      @(posedge clk);
      resetn <= 1'b0;
      @(negedge clk);
      check({r0_n, r1_n, c0_n, c1_n, init_done} === 5'h1E, "pins not parked in reset");
      f0 = falls;
      @(posedge clk);
      resetn <= 1'b1;
      wait_hi("init", 2000);
      check(falls - f0 >= 8, "fewer than eight wake cycles");
      rd_check(1, {9'h005, 9'h003});
   endtask
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      {req_valid, req_write, req_bank, battery_mode} = 4'h0;
      req_addr = 18'h00000;
      req_wdata = 40'h0000000000;
      req_lanes = 2'h3;
      fails = 0;
      checks_done = 0;
      falls = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      wait_hi("init", 2000);
      run_page;
      run_rows;
      run_battery;
      run_idle;
      run_reset;
      summarize;
   end
endmodule
